// ### lprs_pkg.sv
// Shared constants, types and decode functions of the line-locked pixel resampler
`default_nettype none

package lprs_pkg;

  // ==========================================================================
  // Register map (8-bit registers, byte offsets)
  localparam logic [7:0] REG_STD      = 8'h01;
  localparam logic [7:0] REG_RATIO_HI = 8'h02;
  localparam logic [7:0] REG_RATIO_LO = 8'h03;
  localparam logic [7:0] REG_DELAY_A  = 8'h04;
  localparam logic [7:0] REG_DELAY_B  = 8'h05;
  localparam logic [7:0] REG_PIXCNT_HI = 8'h06;
  localparam logic [7:0] REG_PIXCNT_LO = 8'h07;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_MEAS_HI  = 8'h09;
  localparam logic [7:0] REG_MEAS_LO  = 8'h0A;

  // ==========================================================================
  // Reset values
  localparam logic [2:0]  RST_STD     = 3'h1;
  localparam logic [15:0] RST_RATIO   = 16'h02AC;
  localparam logic [7:0]  RST_DELAY_A = 8'h70;
  localparam logic [7:0]  RST_DELAY_B = 8'h5D;
  localparam logic [11:0] RST_PIXCNT  = 12'h000;

  // ==========================================================================
  // Status bit positions
  localparam int ST_LOCKED  = 0;
  localparam int ST_SHORT   = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_BADSTD  = 3;

  // ==========================================================================
  // Input standards (field [2:0] of the standard select register)
  localparam logic [2:0] STD_NONE    = 3'h0;
  localparam logic [2:0] STD_NTSC_M  = 3'h1;
  localparam logic [2:0] STD_NTSC_JP = 3'h2;
  localparam logic [2:0] STD_PAL_BI  = 3'h3;
  localparam logic [2:0] STD_PAL_M   = 3'h4;
  localparam logic [2:0] STD_PAL_N   = 3'h5;
  localparam logic [2:0] STD_SECAM   = 3'h6;
  localparam logic [2:0] STD_PAL_NC  = 3'h7;

  // ==========================================================================
  // Line figures at the pixel rate and phase scale
  localparam logic [11:0] NOM_LEN_525 = 12'h38E;
  localparam logic [11:0] NOM_LEN_625 = 12'h46F;
  localparam logic [11:0] SQ_PIX_525  = 12'h30C;
  localparam logic [11:0] SQ_PIX_625  = 12'h3B0;
  localparam logic [18:0] PHASE_ONE   = 19'h01000;
  localparam int          W_HI        = 11;
  localparam int          W_LO        = 7;

  typedef enum logic [3:0] {
    ST_HUNT  = 4'h1,
    ST_DELAY = 4'h2,
    ST_RUN   = 4'h4,
    ST_FLUSH = 4'h8
  } lprs_state_e;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } lprs_pix_s;

  function automatic logic is_525(input logic [2:0] std);
    return (std == STD_NTSC_M) || (std == STD_NTSC_JP) || (std == STD_PAL_M);
  endfunction : is_525

  function automatic logic [11:0] nominal_len(input logic [2:0] std);
    return is_525(std) ? NOM_LEN_525 : NOM_LEN_625;
  endfunction : nominal_len

  function automatic logic [11:0] square_count(input logic [2:0] std);
    return is_525(std) ? SQ_PIX_525 : SQ_PIX_625;
  endfunction : square_count

endpackage : lprs_pkg

`default_nettype wire

// ### lprs_resampler.sv
// Line-locked pixel resampler: output FIFO and the resampling top level
`default_nettype none

// ============================================================================
// Output FIFO
module lprs_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_over: assert property (@(posedge clk) disable iff (!nrst)
    (push && !pop) |=> (cnt_q == $past(cnt_q) + 1'b1))
    else $error("fifo count did not follow a push");
endmodule : lprs_fifo

// ============================================================================
// Resampler top level
module lprs_top
  import lprs_pkg::*;
#(
  parameter int          FIFO_DEPTH = 16,
  parameter logic [7:0]  SYNC_SLICE = 8'h40,
  parameter logic [11:0] PALNC_MAX  = 12'h384,
  parameter logic [15:0] TRIM_STEP  = 16'h0010,
  parameter logic [15:0] TRIM_MAX   = 16'h0400
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] adc_sample,
  input  wire logic       adc_valid,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic [7:0]      pix_data,
  output logic            pix_valid,
  input  wire logic       pix_ready,
  output logic            line_start_strobe_n
);

  // ==========================================================================
  // Registers
  logic [2:0]  std_q;
  logic [15:0] ratio_q;
  logic [7:0]  delay_a_q;
  logic [7:0]  delay_b_q;
  logic [11:0] pixcnt_q;
  logic        overrun_q;
  logic [7:0]  rdata_q;
  logic [7:0]  status;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      std_q     <= RST_STD;
      ratio_q   <= RST_RATIO;
      delay_a_q <= RST_DELAY_A;
      delay_b_q <= RST_DELAY_B;
      pixcnt_q  <= RST_PIXCNT;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_STD:       std_q          <= reg_wdata[2:0];
        REG_RATIO_HI:  ratio_q[15:8]  <= reg_wdata;
        REG_RATIO_LO:  ratio_q[7:0]   <= reg_wdata;
        REG_DELAY_A:   delay_a_q      <= reg_wdata;
        REG_DELAY_B:   delay_b_q      <= reg_wdata;
        REG_PIXCNT_HI: pixcnt_q[11:8] <= reg_wdata[3:0];
        REG_PIXCNT_LO: pixcnt_q[7:0]  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Double-rate to pixel-rate: pair average, then decimate by two
  logic       half_q;
  logic [7:0] samp_a_q;
  logic [7:0] pix_q;
  logic       pix_stb_q;
  logic [8:0] pair_sum;

  assign pair_sum = {1'b0, samp_a_q} + {1'b0, adc_sample};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      half_q    <= 1'b0;
      samp_a_q  <= 8'h00;
      pix_q     <= 8'h00;
      pix_stb_q <= 1'b0;
    end else begin
      pix_stb_q <= 1'b0;
      if (adc_valid) begin
        half_q <= ~half_q;
        if (!half_q) begin
          samp_a_q <= adc_sample;
        end else begin
          pix_q     <= pair_sum[8:1];
          pix_stb_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Sync midpoint detection and line length measurement
  logic [7:0]  prev_pix_q;
  logic [11:0] line_cnt_q;
  logic [11:0] meas_len_q;
  logic [11:0] nom_len;
  logic        sync_det;

  // Slicing halfway between tip and blank marks the falling-edge midpoint
  assign nom_len  = nominal_len(std_q);
  assign sync_det = pix_stb_q && (prev_pix_q >= SYNC_SLICE) && (pix_q < SYNC_SLICE)
                    && (line_cnt_q >= {1'b0, nom_len[11:1]});

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_pix_q <= 8'h00;
      line_cnt_q <= 12'h000;
      meas_len_q <= 12'h000;
    end else if (pix_stb_q) begin
      prev_pix_q <= pix_q;
      if (sync_det) begin
        meas_len_q <= line_cnt_q;
        line_cnt_q <= 12'h001;
      end else if (line_cnt_q != 12'hFFF) begin
        line_cnt_q <= line_cnt_q + 12'h001;
      end
    end
  end

  // ==========================================================================
  // Target count and phase step
  logic [11:0]        target;
  logic signed [15:0] trim_q;
  logic signed [19:0] step_raw;
  logic [18:0]        step_eff;

  always_comb begin
    target = (pixcnt_q == 12'h000) ? square_count(std_q) : pixcnt_q;
    if ((std_q == STD_PAL_NC) && (target > PALNC_MAX)) begin
      target = PALNC_MAX;
    end
  end

  // Zero ratio gives a one-to-one step: 910 unscaled pixels on 525 lines
  assign step_raw = $signed({1'b0, PHASE_ONE}) + $signed({4'h0, ratio_q}) + 20'(trim_q);
  assign step_eff = (step_raw < $signed({1'b0, PHASE_ONE})) ? PHASE_ONE : step_raw[18:0];

  // ==========================================================================
  // Phase accumulator and push decision
  lprs_state_e state_q;
  logic [18:0] acc_q;
  logic [18:0] acc_sum;
  logic [11:0] out_cnt_q;
  logic [7:0]  dly_q;
  logic [7:0]  last_out_q;
  logic        cap_seen_q;
  logic        emit_want;
  logic        cap_hit;
  logic        push;
  logic        push_ok;
  logic        fifo_ready;
  logic        flush_done;
  logic [18:0] resid;
  logic [4:0]  weight;
  lprs_pix_s   push_pix;
  lprs_pix_s   fifo_out;

  function automatic logic [7:0] lerp(input logic [7:0] a, input logic [7:0] b, input logic [4:0] w);
    logic signed [9:0]  d;
    logic signed [15:0] p;
    logic signed [15:0] r;
    d = $signed({2'b00, b}) - $signed({2'b00, a});
    p = d * $signed({1'b0, w});
    r = $signed({8'h00, b}) - (p >>> 5);
    return r[7:0];
  endfunction : lerp

  assign acc_sum    = acc_q + PHASE_ONE;
  assign resid      = acc_sum - step_eff;
  // Residual is how far behind the current sample the output point sits
  assign weight     = (resid >= PHASE_ONE) ? 5'h1F : resid[W_HI:W_LO];
  assign emit_want  = (state_q == ST_RUN) && pix_stb_q && !sync_det && (acc_sum >= step_eff);
  assign cap_hit    = emit_want && (out_cnt_q >= target);
  assign push       = (emit_want && !cap_hit) || ((state_q == ST_FLUSH) && (out_cnt_q < target));
  assign push_ok    = push && fifo_ready;
  assign flush_done = (out_cnt_q >= target) || (push_ok && (out_cnt_q + 12'h001 >= target));

  always_comb begin
    push_pix.first = (out_cnt_q == 12'h000);
    push_pix.data  = (state_q == ST_FLUSH) ? last_out_q : lerp(prev_pix_q, pix_q, weight);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= 19'h00000;
    end else if (sync_det || (state_q != ST_RUN)) begin
      acc_q <= 19'h00000;
    end else if (pix_stb_q) begin
      acc_q <= (acc_sum >= step_eff) ? resid : acc_sum;
    end
  end

  // ==========================================================================
  // Line sequencing: delay, run, then pad any shortfall before the next line
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q   <= ST_HUNT;
      dly_q     <= 8'h00;
      out_cnt_q <= 12'h000;
    end else begin
      if (push_ok) begin
        out_cnt_q <= out_cnt_q + 12'h001;
      end
      case (state_q)
        ST_HUNT: begin
          if (sync_det) begin
            state_q   <= ST_DELAY;
            dly_q     <= delay_a_q;
            out_cnt_q <= 12'h000;
          end
        end
        ST_DELAY, ST_RUN: begin
          if (sync_det) begin
            if (out_cnt_q < target) begin
              state_q <= ST_FLUSH;
            end else begin
              state_q   <= ST_DELAY;
              dly_q     <= delay_a_q;
              out_cnt_q <= 12'h000;
            end
          end else if ((state_q == ST_DELAY) && pix_stb_q) begin
            if (dly_q == 8'h00) begin
              state_q <= ST_RUN;
            end else begin
              dly_q <= dly_q - 8'h01;
            end
          end
        end
        ST_FLUSH: begin
          if (flush_done) begin
            state_q   <= ST_DELAY;
            dly_q     <= delay_a_q;
            out_cnt_q <= 12'h000;
          end
        end
        default: state_q <= ST_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      last_out_q <= 8'h00;
    end else if (push_ok) begin
      last_out_q <= push_pix.data;
    end
  end

  // ==========================================================================
  // Servo: nudge the step so that padding and dropping stay rare
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_q     <= 16'sh0000;
      cap_seen_q <= 1'b0;
    end else if (sync_det && ((state_q == ST_RUN) || (state_q == ST_DELAY))) begin
      cap_seen_q <= 1'b0;
      if ((out_cnt_q < target) && (trim_q > -$signed(TRIM_MAX))) begin
        trim_q <= trim_q - $signed(TRIM_STEP);
      end else if ((cap_seen_q || cap_hit) && (trim_q < $signed(TRIM_MAX))) begin
        trim_q <= trim_q + $signed(TRIM_STEP);
      end
    end else if (cap_hit) begin
      cap_seen_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Output FIFO; a full FIFO stalls padding and drops live pixels as overrun
  lprs_fifo #(
    .W     ($bits(lprs_pix_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_pix),
    .out_valid (pix_valid),
    .out_ready (pix_ready),
    .out_data  (fifo_out)
  );

  assign pix_data            = fifo_out.data;
  assign line_start_strobe_n = ~(pix_valid && fifo_out.first);

  // ==========================================================================
  // Status and read port
  always_ff @(posedge clk) begin
    if (!nrst) begin
      overrun_q <= 1'b0;
    end else if (emit_want && !cap_hit && !fifo_ready) begin
      overrun_q <= 1'b1;
    end else if (reg_rd && (reg_addr == REG_STATUS)) begin
      overrun_q <= 1'b0;
    end
  end

  always_comb begin
    status              = 8'h00;
    status[ST_LOCKED]   = (state_q != ST_HUNT);
    status[ST_SHORT]    = (state_q != ST_HUNT) && (meas_len_q < target);
    status[ST_OVERRUN]  = overrun_q;
    status[ST_BADSTD]   = (std_q == STD_NONE);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_STD:       rdata_q <= {5'h00, std_q};
        REG_RATIO_HI:  rdata_q <= ratio_q[15:8];
        REG_RATIO_LO:  rdata_q <= ratio_q[7:0];
        REG_DELAY_A:   rdata_q <= delay_a_q;
        REG_DELAY_B:   rdata_q <= delay_b_q;
        REG_PIXCNT_HI: rdata_q <= {4'h0, pixcnt_q[11:8]};
        REG_PIXCNT_LO: rdata_q <= pixcnt_q[7:0];
        REG_STATUS:    rdata_q <= status;
        REG_MEAS_HI:   rdata_q <= {4'h0, meas_len_q[11:8]};
        REG_MEAS_LO:   rdata_q <= meas_len_q[7:0];
        default:       rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================================
  // Checks
  a_decim_pair: assert property (@(posedge clk) disable iff (!nrst)
    (adc_valid && half_q) |=> (pix_stb_q && (pix_q == $past(pair_sum[8:1]))))
    else $error("pixel not formed from sample pair");

  a_decim_half: assert property (@(posedge clk) disable iff (!nrst)
    (adc_valid && !half_q) |=> !pix_stb_q)
    else $error("pixel emitted on first sample of a pair");

  a_line_meas: assert property (@(posedge clk) disable iff (!nrst)
    sync_det |=> (meas_len_q == $past(line_cnt_q)) && (line_cnt_q == 12'h001))
    else $error("line length not captured at sync midpoint");

  a_count_cap: assert property (@(posedge clk) disable iff (!nrst)
    (state_q != ST_HUNT) |-> (out_cnt_q <= target))
    else $error("line exceeded programmed pixel count");

  a_flush_bound: assert property (@(posedge clk) disable iff (!nrst)
    ((state_q == ST_FLUSH) && pix_ready && (target < 12'h3C0)) |-> ##[1:1000] (state_q == ST_DELAY))
    else $error("padding did not finish");

  a_square_def: assert property (@(posedge clk) disable iff (!nrst)
    ((pixcnt_q == 12'h000) && (std_q == STD_PAL_BI)) |-> (target == SQ_PIX_625))
    else $error("square pixel count wrong for 625 lines");

  a_palnc_cap: assert property (@(posedge clk) disable iff (!nrst)
    ((std_q == STD_PAL_NC) && (pixcnt_q == 12'h000)) |-> (target == PALNC_MAX))
    else $error("full count allowed in PAL-N combination");

  a_unscaled_step: assert property (@(posedge clk) disable iff (!nrst)
    ((ratio_q == 16'h0000) && (trim_q <= 16'sh0000)) |-> (step_eff == PHASE_ONE))
    else $error("unscaled step is not one pixel");

  a_ratio_join: assert property (@(posedge clk) disable iff (!nrst)
    (reg_wr && (reg_addr == REG_RATIO_HI)) |=> (ratio_q[15:8] == $past(reg_wdata)))
    else $error("ratio high byte not stored");

  a_emit_step: assert property (@(posedge clk) disable iff (!nrst)
    (emit_want && !sync_det) |=> (acc_q == $past(resid)))
    else $error("accumulator not advanced by one step");

  a_nom_len: assert property (@(posedge clk) disable iff (!nrst)
    (std_q == STD_NTSC_M) |-> (nom_len == NOM_LEN_525))
    else $error("525 nominal line length wrong");

  a_start_mark: assert property (@(posedge clk) disable iff (!nrst)
    (push_ok && push_pix.first && (target > 12'h001)) |=> (out_cnt_q == 12'h001))
    else $error("count did not advance past the first pixel of a line");

endmodule : lprs_top

`default_nettype wire

// ### lprs_video_src.sv
// Video source model: double-rate samples with one sync tip per line
`default_nettype none

module lprs_video_src (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [11:0] line_len,
  output logic [7:0]       adc_sample,
  output logic             adc_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0]  div_q;
  logic [12:0] idx_q;
  logic [7:0]  lvl;

  // ==========================================================================
  // Waveform: sync tip for the first 64 pixels, then a shallow grey ramp
  assign lvl = (idx_q < 13'h0080) ? 8'h10 : {4'h8, idx_q[4:1]};

  // One sample every 7 clocks, as close as the system clock gets to the real rate
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q <= 3'h0;
      idx_q <= 13'h0000;
    end else begin
      div_q <= (div_q == 3'h6) ? 3'h0 : div_q + 3'h1;
      if (div_q == 3'h6)
        idx_q <= (idx_q == ({line_len, 1'b0} - 13'h0001)) ? 13'h0000 : idx_q + 13'h0001;
    end
  end

  assign adc_valid = nrst && (div_q == 3'h6);
  // Between samples the line shows the inverse, so a stale value never passes
  assign adc_sample = adc_valid ? lvl : ~lvl;

endmodule : lprs_video_src

`default_nettype wire

// ### test_line_locked_pixel_resampler.sv
// Self-checking bench of the line-locked pixel resampler
`default_nettype none

module test_line_locked_pixel_resampler import lprs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        pix_ready = 1'b1;
  logic [11:0] line_len = 12'h389;
  logic [7:0]  adc_sample;
  logic        adc_valid;
  logic [7:0]  reg_rdata;
  logic [7:0]  pix_data;
  logic        pix_valid;
  logic        line_start_strobe_n;
  int          failures = 0;
  int          checks = 0;
  int          pix_cnt = 0;
  int          counted = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  lprs_top dut_u (.clk(clk), .nrst(nrst), .adc_sample(adc_sample), .adc_valid(adc_valid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .line_start_strobe_n(line_start_strobe_n));

  lprs_video_src src_u (.clk(clk), .nrst(nrst), .line_len(line_len),
    .adc_sample(adc_sample), .adc_valid(adc_valid));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the read edge, so they are taken there
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    check({8'h00, q}, {8'h00, exp});
  endtask : rd_chk

  task automatic wait_lines(input int n);
    for (int i = 0; i < 30000 && counted < n; i++)
      @(posedge clk);
  endtask : wait_lines

  // ==========================================================================
  // Pixel counter: every first-of-line pixel closes the count of the line before
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      tally_and_finish();
    end
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      check({15'h0000, (pix_data >= 8'h10) && (pix_data <= 8'h8F)}, 16'h0001);
      if (line_start_strobe_n === 1'b0) begin
        if (pix_cnt > 0) begin
          check(pix_cnt[15:0], {4'h0, SQ_PIX_525});
          counted++;
        end
        pix_cnt = 1;
      end else if (pix_cnt > 0)
        pix_cnt++;
    end
  end

  // ==========================================================================
  // Scenarios
  task automatic reset_values();
    rd_chk(REG_STD, {5'h00, RST_STD});
    rd_chk(REG_RATIO_HI, RST_RATIO[15:8]);
    rd_chk(REG_RATIO_LO, RST_RATIO[7:0]);
    rd_chk(REG_DELAY_A, RST_DELAY_A);
    rd_chk(REG_DELAY_B, RST_DELAY_B);
    #4 check({8'h00, reg_rdata}, 16'h0000);
    rd_chk(8'h20, 8'h00);
  endtask : reset_values

  task automatic std_codes();
    logic [7:0] q;
    wr(REG_STD, 8'h00);
    rd(REG_STATUS, q);
    check({15'h0000, q[ST_BADSTD]}, 16'h0001);
    for (int i = 1; i < 8; i++) begin
      wr(REG_STD, 8'(i));
      rd_chk(REG_STD, 8'(i));
    end
    // The pixel count registers take and return the 625-line square count
    wr(REG_PIXCNT_HI, {4'h0, SQ_PIX_625[11:8]});
    wr(REG_PIXCNT_LO, SQ_PIX_625[7:0]);
    rd_chk(REG_PIXCNT_HI, {4'h0, SQ_PIX_625[11:8]});
    rd_chk(REG_PIXCNT_LO, SQ_PIX_625[7:0]);
    wr(REG_PIXCNT_HI, 8'h00);
    wr(REG_PIXCNT_LO, 8'h00);
    wr(REG_STD, {5'h00, STD_NTSC_M});
  endtask : std_codes

  task automatic ratio_bytes();
    wr(REG_RATIO_HI, 8'h03);
    wr(REG_RATIO_LO, 8'h3C);
    rd_chk(REG_RATIO_HI, 8'h03);
    rd_chk(REG_RATIO_LO, 8'h3C);
    wr(REG_RATIO_HI, 8'h00);
    wr(REG_RATIO_LO, 8'h00);
    rd_chk(REG_RATIO_LO, 8'h00);
    wr(REG_RATIO_HI, RST_RATIO[15:8]);
    wr(REG_RATIO_LO, RST_RATIO[7:0]);
  endtask : ratio_bytes

  // Short, long, then nominal lines; a long stall forces drops that padding must hide
  task automatic line_stream();
    logic [7:0] q;
    wait_lines(1);
    line_len <= 12'h391;
    pix_ready <= 1'b0;
    repeat (1500) @(posedge clk);
    pix_ready <= 1'b1;
    wait_lines(2);
    line_len <= NOM_LEN_525;
    wait_lines(3);
    check(counted[15:0], 16'h0003);
    rd_chk(REG_MEAS_HI, {4'h0, NOM_LEN_525[11:8]});
    rd_chk(REG_MEAS_LO, NOM_LEN_525[7:0]);
    rd(REG_STATUS, q);
    check({15'h0000, q[ST_OVERRUN]}, 16'h0001);
    check({15'h0000, q[ST_LOCKED]}, 16'h0001);
    check({15'h0000, q[ST_SHORT]}, 16'h0000);
    check({15'h0000, q[ST_BADSTD]}, 16'h0000);
    rd(REG_STATUS, q);
    check({15'h0000, q[ST_OVERRUN]}, 16'h0000);
  endtask : line_stream

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    std_codes();
    ratio_bytes();
    line_stream();
    tally_and_finish();
  end

endmodule : test_line_locked_pixel_resampler

`default_nettype wire
